// File: common/fmi_pkg.sv
// Package for the fuzzy MCU jump, load and interrupt-control executor.
`default_nettype none
package fmi_pkg;
  // ==========================================================================
  // Widths and limits
  localparam int PC_W = 11;
  localparam int CNT_W = 3;
  localparam logic [3:0] FZ_MAX = 4'hf;
  localparam logic [1:0] PAR_PORT_IDX = 2'h2;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ = 12'h008;
  localparam logic [11:0] OFS_PROG_ADDR = 12'h00c;
  localparam logic [11:0] OFS_PROG_DATA = 12'h010;
  localparam logic [11:0] OFS_MF_ADDR = 12'h014;
  localparam logic [11:0] OFS_MF_DATA = 12'h018;
  localparam logic [11:0] OFS_FUZZ = 12'h01c;
  localparam logic [11:0] OFS_FOUT = 12'h020;
  localparam logic [11:0] OFS_RF_BASE = 12'h040;
  localparam logic [11:0] OFS_CF_BASE = 12'h080;
  localparam logic [11:0] OFS_VEC_BASE = 12'h0c0;

  // ==========================================================================
  // Field positions
  localparam int ST_Z_BIT = 16;
  localparam int ST_S_BIT = 17;
  localparam int ST_MGI_BIT = 18;
  localparam int ST_UGI_BIT = 19;
  localparam int ST_RUNNING_BIT = 20;
  localparam int IRQ_MASK_LSB = 8;
  localparam int IRQ_SERV_LSB = 16;
  localparam int FZ_K_LSB = 8;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPZ_LOAD_REG_FROM_INPUT = 8'b0000_????;
  localparam logic [7:0] OPZ_CANCEL_PENDING_IRQ = 8'b0001_????;
  localparam logic [7:0] OPZ_STORE_TO_PERIPHERAL = 8'b01??_????;
  localparam logic [7:0] OPZ_LOAD_REG_IMMEDIATE = 8'b1000_????;
  localparam logic [7:0] OPZ_LOAD_CONFIG_IMMEDIATE = 8'b1011_????;
  localparam logic [7:0] OPZ_JP = 8'b1010_????;
  localparam logic [7:0] OPZ_JUMP_IF_SIGN_CLEAR = 8'b1111_????;
  localparam logic [7:0] OPZ_JUMP_IF_ZERO_CLEAR = 8'b1101_????;
  localparam logic [7:0] OPZ_JPS = 8'b1110_????;
  localparam logic [7:0] OPZ_JPZ = 8'b1100_????;
  localparam logic [7:0] OP_COPY_REG_TO_REG = 8'h96;
  localparam logic [7:0] OP_RETURN_FROM_HANDLER = 8'h95;
  localparam logic [7:0] OP_USER_IRQ_DISABLE = 8'h98;
  localparam logic [7:0] OP_USER_IRQ_ENABLE = 8'h99;
  localparam logic [7:0] OP_MACRO_IRQ_DISABLE = 8'h9a;
  localparam logic [7:0] OP_MACRO_IRQ_ENABLE = 8'h9b;
  localparam logic [7:0] OP_SRX = 8'h9c;
  localparam logic [7:0] OP_LDK = 8'h20;
  localparam logic [7:0] OP_LDM = 8'h21;
  localparam logic [7:0] OP_SKM = 8'h22;
  localparam logic [7:0] OP_OUT = 8'h23;
  localparam logic [7:0] OP_LDP = 8'h24;
  localparam logic [7:0] OP_LDN = 8'h25;

  // ==========================================================================
  // Cycle counts per instruction
  localparam logic [CNT_W-1:0] CYC_4 = 3'd4;
  localparam logic [CNT_W-1:0] CYC_5 = 3'd5;
  localparam logic [CNT_W-1:0] CYC_6 = 3'd6;
  localparam logic [CNT_W-1:0] CYC_WAIT_ADJ = 3'd2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_WAIT = 2'b10
  } fmi_state_e;

  typedef struct packed {
    logic [7:0] lvd;
    logic [7:0] vtx;
    logic [7:0] rvd;
  } fmi_mf_s;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic z;
    logic s;
  } fmi_save_s;
endpackage : fmi_pkg
`default_nettype wire

// File: rtl/fmi_exec.sv
// Instruction executor for jumps, loads, fuzzy stack and interrupt control.
// Behaviour
// [RULE1] Unconditional jump loads PC from two-byte operand, six cycles, flags kept.
// [RULE2] Jump-if-sign-clear jumps only when S is zero, else continues.
// [RULE3] Jump-if-zero-clear jumps only when Z is zero, else continues.
// [RULE4] Jump-if-sign-set jumps only when S is one, flags untouched.
// [RULE5] Jump-if-zero-set jumps only when Z is one; conditional jumps two bytes, six cycles.
// [RULE6] Config load writes immediate into selected configuration register, six cycles.
// [RULE7] Push fuzzy result register onto the fuzzy stack top.
// [RULE8] Push temporary buffer register onto the fuzzy stack top.
// [RULE9] Negated fuzzification pushes fifteen minus the membership truth degree.
// [RULE10] Positive fuzzification pushes the membership truth degree unchanged.
// [RULE11] Peripheral store copies a register, one byte, five cycles, six for parallel port.
// [RULE12] Register immediate load writes constant into register file, six cycles.
// [RULE13] Input load copies an input register into the register file, six cycles.
// [RULE14] Register copy, two bytes, six cycles; second operand source, first destination.
// [RULE15] Macro disable clears macro enable bit; interrupts then stay pending.
// [RULE16] Macro enable sets the bit; acceptance also needs the user enable bit.
// [RULE17] Output computation defuzzifies into fuzzy output zero or one only.
// [RULE18] Interrupt return restores PC, Z and S, five cycles.
// [RULE19] Cancel clears the pending bit unless that interrupt is in service.
// [RULE20] Store-result copies fuzzy result register into the temporary buffer.
// [RULE21] Serial read copies receive data into a register, two bytes, five cycles.
// [RULE22] User disable clears, user enable sets the user bit; both needed to acknowledge.
// [RULE23] Acknowledge saves return PC and flags so the return can restore them.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module fmi_exec #(
  parameter int NUM_IRQ = 8,
  parameter int NUM_RF = 16,
  parameter int NUM_CF = 16,
  parameter int NUM_IN = 16,
  parameter int PROG_DEPTH = 2048,
  parameter int MF_DEPTH = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral side, same clock
  input wire logic [NUM_IN*8-1:0] input_regs,
  input wire logic [7:0] serial_receive_data,
  input wire logic [15:0] defuzz_dividend,
  input wire logic [15:0] defuzz_divisor,
  input wire logic [NUM_IRQ-1:0] irq_req,
  // Results
  output logic [31:0] periph_regs,
  output logic [3:0] periph_wr,
  output logic [NUM_CF*8-1:0] config_regs,
  output logic [15:0] fuzzy_out,
  output logic irq_ack
);

  // ==========================================================================
  // Storage and state
  logic [7:0] prog_mem [PROG_DEPTH];
  fmi_pkg::fmi_mf_s mf_mem [MF_DEPTH];
  logic [7:0] rf [NUM_RF];
  logic [fmi_pkg::PC_W-1:0] vec [NUM_IRQ];
  fmi_pkg::fmi_state_e state;
  logic [fmi_pkg::CNT_W-1:0] cnt;
  logic [fmi_pkg::PC_W-1:0] pc;
  logic run;
  logic flag_z;
  logic flag_s;
  logic macro_global_irq_bit;
  logic user_global_irq_bit;
  logic [NUM_IRQ-1:0] pending;
  logic [NUM_IRQ-1:0] mask;
  logic [NUM_IRQ-1:0] in_service;
  fmi_pkg::fmi_save_s saved;
  logic [3:0] stack0;
  logic [3:0] stack1;
  logic [3:0] fz_k;
  logic [3:0] fz_m;
  logic [10:0] prog_addr;
  logic [5:0] mf_addr;

  // ==========================================================================
  // APB access decode
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_hit;
  assign apb_wr = psel & penable & pwrite & pready;

  // ==========================================================================
  // Fetch and decode
  logic [7:0] op0;
  logic [7:0] op1;
  logic [fmi_pkg::PC_W-1:0] tgt;
  logic [1:0] len;
  logic [fmi_pkg::CNT_W-1:0] cyc;
  logic jmp;
  logic rf_we;
  logic [3:0] rf_wa;
  logic [7:0] rf_wd;
  logic cf_we;
  logic pr_we;
  logic push;
  logic [3:0] push_val;
  logic save_result_to_buffer;
  logic out_we;
  logic mgi_clr;
  logic mgi_set;
  logic ugi_clr;
  logic ugi_set;
  logic return_from_handler;
  logic cancel_pending_irq;
  logic [NUM_IRQ-1:0] live;
  logic take_irq;
  logic exec;
  logic [$clog2(NUM_IRQ)-1:0] ack_idx;
  logic [3:0] alpha;
  logic [7:0] defuzz_val;

  assign op0 = prog_mem[pc];
  assign op1 = prog_mem[pc + fmi_pkg::PC_W'(1)];
  assign tgt = {op0[fmi_pkg::PC_W-9:0], op1};
  assign live = pending & mask & ~in_service;
  // [RULE22] both enables gate acceptance
  assign take_irq = (state == fmi_pkg::ST_DECODE) && macro_global_irq_bit
                    && user_global_irq_bit && (in_service == '0) && (live != '0);
  assign exec = (state == fmi_pkg::ST_DECODE) && !take_irq;

  // Lowest numbered live interrupt wins.
  always_comb begin
    ack_idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (live[i]) begin
        ack_idx = i[$clog2(NUM_IRQ)-1:0];
      end
    end
  end

  // Truth degree of a triangular membership function (vertex, left and right widths).
  function automatic logic [3:0] truth(input logic [7:0] x, input fmi_pkg::fmi_mf_s mf);
    logic [7:0] d;
    logic [7:0] w;
    logic [11:0] num;
    if (x <= mf.vtx) begin
      d = mf.vtx - x;
      w = mf.lvd;
    end else begin
      d = x - mf.vtx;
      w = mf.rvd;
    end
    num = 12'((w - d) * 8'(fmi_pkg::FZ_MAX)) / {4'h0, w};
    if (d == 8'h00) begin
      truth = fmi_pkg::FZ_MAX;
    end else if (d >= w) begin
      truth = 4'h0;
    end else begin
      truth = num[3:0];
    end
  endfunction : truth

  assign alpha = truth(input_regs[8*op1[5:4] +: 8], mf_mem[op1[5:0]]);
  // A zero divisor means no rule fired, so the output reads zero instead of undefined.
  assign defuzz_val = (defuzz_divisor == 16'h0000) ? 8'h00
                      : 8'(defuzz_dividend / defuzz_divisor);

  always_comb begin
    len = 2'd1;
    cyc = fmi_pkg::CYC_4;
    jmp = 1'b0;
    rf_we = 1'b0;
    rf_wa = op0[3:0];
    rf_wd = op1;
    cf_we = 1'b0;
    pr_we = 1'b0;
    push = 1'b0;
    push_val = fz_k;
    save_result_to_buffer = 1'b0;
    out_we = 1'b0;
    mgi_clr = 1'b0;
    mgi_set = 1'b0;
    ugi_clr = 1'b0;
    ugi_set = 1'b0;
    return_from_handler = 1'b0;
    cancel_pending_irq = 1'b0;
    casez (op0)
      // [RULE13] input register load
      fmi_pkg::OPZ_LOAD_REG_FROM_INPUT: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        rf_we = 1'b1;
        rf_wa = op1[7:4];
        rf_wd = input_regs[8*op1[3:0] +: 8];
      end
      fmi_pkg::OPZ_CANCEL_PENDING_IRQ: cancel_pending_irq = 1'b1;
      // [RULE11] peripheral store timing
      fmi_pkg::OPZ_STORE_TO_PERIPHERAL: begin
        pr_we = 1'b1;
        cyc = (op0[5:4] == fmi_pkg::PAR_PORT_IDX) ? fmi_pkg::CYC_6 : fmi_pkg::CYC_5;
      end
      // [RULE12] immediate register load
      fmi_pkg::OPZ_LOAD_REG_IMMEDIATE: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        rf_we = 1'b1;
      end
      // [RULE6] configuration load
      fmi_pkg::OPZ_LOAD_CONFIG_IMMEDIATE: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        cf_we = 1'b1;
      end
      // [RULE1] unconditional jump
      fmi_pkg::OPZ_JP: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        jmp = 1'b1;
      end
      // [RULE2] jump on sign clear
      fmi_pkg::OPZ_JUMP_IF_SIGN_CLEAR: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        jmp = !flag_s;
      end
      // [RULE3] jump on zero clear
      fmi_pkg::OPZ_JUMP_IF_ZERO_CLEAR: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        jmp = !flag_z;
      end
      // [RULE4] jump on sign set
      fmi_pkg::OPZ_JPS: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        jmp = flag_s;
      end
      // [RULE5] jump on zero set
      fmi_pkg::OPZ_JPZ: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        jmp = flag_z;
      end
      // [RULE14] second operand is the source
      fmi_pkg::OP_COPY_REG_TO_REG: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_6;
        rf_we = 1'b1;
        rf_wa = op1[7:4];
        rf_wd = rf[op1[3:0]];
      end
      // [RULE18] return takes five cycles
      fmi_pkg::OP_RETURN_FROM_HANDLER: begin
        cyc = fmi_pkg::CYC_5;
        return_from_handler = 1'b1;
      end
      fmi_pkg::OP_USER_IRQ_DISABLE: ugi_clr = 1'b1;
      fmi_pkg::OP_USER_IRQ_ENABLE: ugi_set = 1'b1;
      fmi_pkg::OP_MACRO_IRQ_DISABLE: mgi_clr = 1'b1;
      fmi_pkg::OP_MACRO_IRQ_ENABLE: mgi_set = 1'b1;
      // [RULE21] serial receive transfer
      fmi_pkg::OP_SRX: begin
        len = 2'd2;
        cyc = fmi_pkg::CYC_5;
        rf_we = 1'b1;
        rf_wa = op1[3:0];
        rf_wd = serial_receive_data;
      end
      // [RULE7] push fuzzy result
      fmi_pkg::OP_LDK: push = 1'b1;
      // [RULE8] push temporary buffer
      fmi_pkg::OP_LDM: begin
        push = 1'b1;
        push_val = fz_m;
      end
      fmi_pkg::OP_SKM: save_result_to_buffer = 1'b1;
      fmi_pkg::OP_OUT: begin
        len = 2'd2;
        out_we = 1'b1;
      end
      // [RULE10] positive truth degree
      fmi_pkg::OP_LDP: begin
        len = 2'd2;
        push = 1'b1;
        push_val = alpha;
      end
      // [RULE9] negated truth degree
      fmi_pkg::OP_LDN: begin
        len = 2'd2;
        push = 1'b1;
        push_val = fmi_pkg::FZ_MAX - alpha;
      end
      default: len = 2'd1;
    endcase
  end

  // ==========================================================================
  // Sequencer, program counter and saved context
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fmi_pkg::ST_IDLE;
      cnt <= '0;
      pc <= '0;
      saved <= '0;
    end else begin
      case (state)
        fmi_pkg::ST_IDLE: begin
          if (run) begin
            state <= fmi_pkg::ST_DECODE;
          end
        end
        fmi_pkg::ST_DECODE: begin
          state <= fmi_pkg::ST_WAIT;
          if (take_irq) begin
            // [RULE23] save return context
            saved <= '{pc: pc, z: flag_z, s: flag_s};
            pc <= vec[ack_idx];
            cnt <= fmi_pkg::CYC_4 - fmi_pkg::CYC_WAIT_ADJ;
          end else begin
            cnt <= cyc - fmi_pkg::CYC_WAIT_ADJ;
            if (return_from_handler) begin
              // [RULE18] restore program counter
              pc <= saved.pc;
            end else if (jmp) begin
              pc <= tgt;
            end else begin
              pc <= pc + fmi_pkg::PC_W'(len);
            end
          end
        end
        fmi_pkg::ST_WAIT: begin
          if (cnt != '0) begin
            cnt <= cnt - 3'd1;
          end else begin
            state <= run ? fmi_pkg::ST_DECODE : fmi_pkg::ST_IDLE;
          end
        end
        default: state <= fmi_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Flags and global enables; the core wins over a software write in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_z <= 1'b0;
      flag_s <= 1'b0;
      macro_global_irq_bit <= 1'b0;
      user_global_irq_bit <= 1'b0;
    end else begin
      if (apb_wr && paddr == fmi_pkg::OFS_STATUS) begin
        flag_z <= pwdata[fmi_pkg::ST_Z_BIT];
        flag_s <= pwdata[fmi_pkg::ST_S_BIT];
        macro_global_irq_bit <= pwdata[fmi_pkg::ST_MGI_BIT];
        user_global_irq_bit <= pwdata[fmi_pkg::ST_UGI_BIT];
      end
      if (exec && return_from_handler) begin
        // [RULE18] restore flags
        flag_z <= saved.z;
        flag_s <= saved.s;
      end
      // [RULE15] macro disable
      if (exec && mgi_clr) begin
        macro_global_irq_bit <= 1'b0;
      end
      // [RULE16] macro enable
      if (exec && mgi_set) begin
        macro_global_irq_bit <= 1'b1;
      end
      // [RULE22] user enable bit
      if (exec && ugi_clr) begin
        user_global_irq_bit <= 1'b0;
      end
      if (exec && ugi_set) begin
        user_global_irq_bit <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Interrupt pending and in-service bits; a new request beats a cancel.
  logic [NUM_IRQ-1:0] pend_clr;
  always_comb begin
    pend_clr = '0;
    // [RULE19] cancel unless in service
    if (exec && cancel_pending_irq && !in_service[op0[2:0]]) begin
      pend_clr[op0[2:0]] = 1'b1;
    end
    if (take_irq) begin
      pend_clr[ack_idx] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= '0;
      in_service <= '0;
      irq_ack <= 1'b0;
      mask <= '0;
    end else begin
      pending <= (pending & ~pend_clr) | irq_req;
      irq_ack <= take_irq;
      if (take_irq) begin
        in_service[ack_idx] <= 1'b1;
      end else if (exec && return_from_handler) begin
        in_service <= '0;
      end
      if (apb_wr && paddr == fmi_pkg::OFS_IRQ) begin
        mask <= pwdata[fmi_pkg::IRQ_MASK_LSB +: NUM_IRQ];
      end
    end
  end

  // ==========================================================================
  // Register file, configuration and peripheral registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_RF; i++) begin
        rf[i] <= 8'h00;
      end
    end else if (exec && rf_we) begin
      rf[rf_wa] <= rf_wd;
    end else if (apb_wr && paddr[11:6] == fmi_pkg::OFS_RF_BASE[11:6]) begin
      rf[paddr[5:2]] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_regs <= '0;
      periph_regs <= '0;
      periph_wr <= '0;
    end else begin
      periph_wr <= '0;
      if (exec && cf_we) begin
        config_regs[8*op0[3:0] +: 8] <= op1;
      end
      if (exec && pr_we) begin
        periph_regs[8*op0[5:4] +: 8] <= rf[op0[3:0]];
        periph_wr[op0[5:4]] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Fuzzy stack, temporary registers and defuzzified outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack0 <= '0;
      stack1 <= '0;
      fz_k <= '0;
      fz_m <= '0;
      fuzzy_out <= '0;
    end else begin
      if (exec && push) begin
        stack1 <= stack0;
        stack0 <= push_val;
      end
      // [RULE20] save result to buffer
      if (exec && save_result_to_buffer) begin
        fz_m <= fz_k;
      end
      if (apb_wr && paddr == fmi_pkg::OFS_FUZZ) begin
        fz_k <= pwdata[fmi_pkg::FZ_K_LSB +: 4];
      end
      // [RULE17] only outputs zero and one
      if (exec && out_we && op1[7:1] == 7'h00) begin
        fuzzy_out[8*op1[0] +: 8] <= defuzz_val;
      end
    end
  end

  // ==========================================================================
  // Software-loaded tables and control
  always_ff @(posedge pclk) begin
    if (apb_wr && paddr == fmi_pkg::OFS_PROG_DATA) begin
      prog_mem[prog_addr] <= pwdata[7:0];
    end
    if (apb_wr && paddr == fmi_pkg::OFS_MF_DATA) begin
      mf_mem[mf_addr] <= pwdata[23:0];
    end
    if (apb_wr && paddr[11:5] == fmi_pkg::OFS_VEC_BASE[11:5]) begin
      vec[paddr[4:2]] <= pwdata[fmi_pkg::PC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      prog_addr <= '0;
      mf_addr <= '0;
    end else if (apb_wr) begin
      if (paddr == fmi_pkg::OFS_CTRL) begin
        run <= pwdata[0];
      end
      if (paddr == fmi_pkg::OFS_PROG_ADDR) begin
        prog_addr <= pwdata[10:0];
      end
      if (paddr == fmi_pkg::OFS_PROG_DATA) begin
        prog_addr <= prog_addr + 11'd1;
      end
      if (paddr == fmi_pkg::OFS_MF_ADDR) begin
        mf_addr <= pwdata[5:0];
      end
      if (paddr == fmi_pkg::OFS_MF_DATA) begin
        mf_addr <= mf_addr + 6'd1;
      end
    end
  end

  // ==========================================================================
  // APB read path; data is captured in the setup phase so every access has no wait state.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr[11:6] == fmi_pkg::OFS_RF_BASE[11:6]) begin
      rd_mux[7:0] = rf[paddr[5:2]];
    end else if (paddr[11:6] == fmi_pkg::OFS_CF_BASE[11:6]) begin
      rd_mux[7:0] = config_regs[8*paddr[5:2] +: 8];
    end else if (paddr[11:5] == fmi_pkg::OFS_VEC_BASE[11:5]) begin
      rd_mux[fmi_pkg::PC_W-1:0] = vec[paddr[4:2]];
    end else begin
      case (paddr)
        fmi_pkg::OFS_CTRL: rd_mux[0] = run;
        fmi_pkg::OFS_STATUS: begin
          rd_mux[fmi_pkg::PC_W-1:0] = pc;
          rd_mux[fmi_pkg::ST_Z_BIT] = flag_z;
          rd_mux[fmi_pkg::ST_S_BIT] = flag_s;
          rd_mux[fmi_pkg::ST_MGI_BIT] = macro_global_irq_bit;
          rd_mux[fmi_pkg::ST_UGI_BIT] = user_global_irq_bit;
          rd_mux[fmi_pkg::ST_RUNNING_BIT] = (state != fmi_pkg::ST_IDLE);
        end
        fmi_pkg::OFS_IRQ: begin
          rd_mux[NUM_IRQ-1:0] = pending;
          rd_mux[fmi_pkg::IRQ_MASK_LSB +: NUM_IRQ] = mask;
          rd_mux[fmi_pkg::IRQ_SERV_LSB +: NUM_IRQ] = in_service;
        end
        fmi_pkg::OFS_PROG_ADDR: rd_mux[10:0] = prog_addr;
        fmi_pkg::OFS_PROG_DATA: rd_mux[7:0] = prog_mem[prog_addr];
        fmi_pkg::OFS_MF_ADDR: rd_mux[5:0] = mf_addr;
        fmi_pkg::OFS_MF_DATA: rd_mux[23:0] = mf_mem[mf_addr];
        fmi_pkg::OFS_FUZZ: rd_mux[15:0] = {fz_m, fz_k, stack1, stack0};
        fmi_pkg::OFS_FOUT: rd_mux[15:0] = fuzzy_out;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule : fmi_exec
`default_nettype wire

// File: tb/fmi_exec_props.sv
// Port timing checker for the jump, load and interrupt executor.
`timescale 1ns/10ps
`default_nettype none
module fmi_exec_chk (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Results
  input wire logic [31:0] periph_regs,
  input wire logic [3:0] periph_wr,
  input wire logic irq_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pwr_s;
    |periph_wr;
  endsequence
  setup_ready_a: assert property (setup_s |=> pready) else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  pwr_gap_a: assert property (pwr_s |=> !(|periph_wr) [*4]) else $error("store too fast");
  pwr_onehot_a: assert property ($onehot0(periph_wr)) else $error("two stores");
  preg_cause_a: assert property (!$stable(periph_regs) |-> pwr_s) else $error("silent store");
  ack_gap_a: assert property (irq_ack |=> !irq_ack [*3]) else $error("ack too fast");
endmodule : fmi_exec_chk
bind fmi_exec fmi_exec_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .periph_regs(periph_regs),
  .periph_wr(periph_wr), .irq_ack(irq_ack));
`default_nettype wire

// File: tb/fmi_exec_tb.sv
// Bench that loads a program over the register bus, runs it and reads results back.
`timescale 1ns/10ps
`default_nettype none
module fmi_exec_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [127:0] input_regs = 128'h770000;
  logic [7:0] rx_data = 8'h5a;
  logic [7:0] irq_req = 8'h00;
  logic [15:0] dvd = 16'h0060;
  logic [15:0] dvs = 16'h0004;
  logic [31:0] periph_regs;
  logic [3:0] periph_wr;
  logic [127:0] config_regs;
  logic [15:0] fuzzy_out;
  logic irq_ack;
  logic [31:0] rd;
  logic err;
  int n;
  int miscompares = 0;
  int checks = 0;
  always #12.5 pclk = ~pclk;
  fmi_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_regs(input_regs), .serial_receive_data(rx_data),
    .defuzz_dividend(dvd), .defuzz_divisor(dvs), .irq_req(irq_req),
    .periph_regs(periph_regs), .periph_wr(periph_wr), .config_regs(config_regs),
    .fuzzy_out(fuzzy_out), .irq_ack(irq_ack));
  // ==========================================================================
  // Access tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask : rdchk
  task automatic load(input logic [11:0] a, input logic [7:0] q[$]);
    apb(1'b1, fmi_pkg::OFS_PROG_ADDR, {20'h0, a});
    foreach (q[i]) apb(1'b1, fmi_pkg::OFS_PROG_DATA, {24'h0, q[i]});
  endtask : load
  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Tests
  initial begin
    #(4000 * 25);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status rst", fmi_pkg::OFS_STATUS, 32'h1f07ff, 32'h0);
    apb(1'b0, 12'h800, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // The zero-flag jump must fall through: its target holds no code.
    load(12'h000, '{8'h85, 8'h2b, 8'h96, 8'h35, 8'hb5, 8'h43, 8'h63, 8'h00, 8'h62,
                    8'h9c, 8'h07, 8'hc0, 8'h40, 8'hd0, 8'h20});
    load(12'h020, '{8'h9b, 8'h99, 8'h22, 8'h24, 8'h00, 8'h25, 8'h00, 8'h23, 8'h02, 8'ha0,
                    8'h29});
    load(12'h030, '{8'h20, 8'h21, 8'h23, 8'h01, 8'h9a, 8'h95});
    apb(1'b1, fmi_pkg::OFS_VEC_BASE, 32'h030);
    apb(1'b1, fmi_pkg::OFS_IRQ, 32'h0100);
    apb(1'b1, fmi_pkg::OFS_FUZZ, 32'h0900);
    apb(1'b1, fmi_pkg::OFS_MF_DATA, 32'h080408);
    apb(1'b1, fmi_pkg::OFS_CTRL, 32'h1);
    // Straight-line code takes 72 cycles before the loop is reached.
    repeat (80) @(posedge pclk);
    rdchk("rf5", fmi_pkg::OFS_RF_BASE + 12'h14, 32'hff, 32'h2b);
    rdchk("rf3", fmi_pkg::OFS_RF_BASE + 12'h0c, 32'hff, 32'h2b);
    rdchk("rf6", fmi_pkg::OFS_RF_BASE + 12'h18, 32'hff, 32'h77);
    rdchk("rf7", fmi_pkg::OFS_RF_BASE + 12'h1c, 32'hff, 32'h5a);
    chk("cf5", {24'h0, config_regs[47:40]}, 32'h43);
    chk("per2", {24'h0, periph_regs[23:16]}, 32'h2b);
    rdchk("status run", fmi_pkg::OFS_STATUS, 32'h0f07ff, 32'h0c0029);
    rdchk("fuzz run", fmi_pkg::OFS_FUZZ, 32'hffff, 32'h9978);
    chk("fout bad", {16'h0, fuzzy_out}, 32'h0);
    apb(1'b1, fmi_pkg::OFS_FUZZ, 32'h0300);
    irq_req <= 8'h01;
    @(posedge pclk);
    irq_req <= 8'h00;
    n = 0;
    while (irq_ack !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    chk("ack", {31'h0, irq_ack}, 32'h1);
    repeat (40) @(posedge pclk);
    rdchk("irq", fmi_pkg::OFS_IRQ, 32'hffffff, 32'h0100);
    rdchk("status ret", fmi_pkg::OFS_STATUS, 32'h0f07ff, 32'h080029);
    rdchk("fuzz isr", fmi_pkg::OFS_FUZZ, 32'hffff, 32'h9339);
    chk("fout1", {16'h0, fuzzy_out}, 32'h1800);
    irq_req <= 8'h01;
    @(posedge pclk);
    irq_req <= 8'h00;
    rdchk("irq held", fmi_pkg::OFS_IRQ, 32'hffffff, 32'h0101);
    tally_and_finish();
  end
endmodule : fmi_exec_tb
`default_nettype wire
